// file: logic/cmpcsr_regs.svh
// Register offsets, field positions and reset values of the comparator control block
// How it works
// - Writing one to bit 7 turns the comparator on; zero turns it off.
// - Bit 6 reads the comparison result: one when plus input exceeds minus.
// - Bit 5 sets on a rising result edge and stays until software clears it.
// - Bit 4 sets on a falling result edge and stays until software clears it.
// - Bits 3-2 select positive hysteresis: off, 5 mV, 10 mV, 20 mV.
// - Bits 1-0 select negative hysteresis: off, 5 mV, 10 mV, 20 mV.
// - The register is decoded at special function register address 0x9b.
// - Edge flags stay set until software writes zero or a reset occurs; result edges never clear them.
`ifndef CMPCSR_REGS_SVH
`define CMPCSR_REGS_SVH

// ==========================================
// Address and fields
`define CMPCSR_ADDR 8'h9b
`define CMPCSR_BIT_ON 7
`define CMPCSR_BIT_RESULT 6
`define CMPCSR_BIT_RISE 5
`define CMPCSR_BIT_FALL 4
`define CMPCSR_UPPER_HI 3
`define CMPCSR_UPPER_LO 2
`define CMPCSR_LOWER_HI 1
`define CMPCSR_LOWER_LO 0

// ==========================================
// Reset values
`define CMPCSR_RESET_VAL 8'h00
`define CMPCSR_HYST_RESET 2'h0

`endif

// file: logic/cmpcsr_pkg.sv
// Types shared by the comparator control block
package cmpcsr_pkg;

	// ==========================================
	// Hysteresis codes
	typedef enum logic [1:0] {
		CMPCSR_HYST_OFF = 2'h0,
		CMPCSR_HYST_5MV = 2'h1,
		CMPCSR_HYST_10MV = 2'h2,
		CMPCSR_HYST_20MV = 2'h3
	} cmpcsr_hyst_type;

	// ==========================================
	// Settings driven to the analog core
	typedef struct packed {
		logic comparator_on;
		cmpcsr_hyst_type upper_hysteresis_sel;
		cmpcsr_hyst_type lower_hysteresis_sel;
	} cmpcsr_ctrl_type;

	// ==========================================
	// Special function register access
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cmpcsr_sfr_req_type;

endpackage : cmpcsr_pkg

// file: logic/cmpcsr_edge.sv
// Synchroniser and edge detector for the comparator result
`timescale 1ns/100ps
module cmpcsr_edge (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// ==========================================
	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o = sync_q & ~prev_q;
	assign fall_o = ~sync_q & prev_q;

endmodule : cmpcsr_edge

// file: logic/cmpcsr_top.sv
// Comparator control and status register with edge event flags
`timescale 1ns/100ps
`include "cmpcsr_regs.svh"
module cmpcsr_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire cmpcsr_pkg::cmpcsr_sfr_req_type sfr_req_i,
	input wire logic compare_result_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_sel_o,
	output cmpcsr_pkg::cmpcsr_ctrl_type ctrl_o
);

	logic hit;
	logic wr_hit;
	logic result_sync;
	logic rise_evt;
	logic fall_evt;
	logic comparator_on_q;
	logic [1:0] upper_hysteresis_sel_q;
	logic [1:0] lower_hysteresis_sel_q;
	logic rise_event_flag_q;
	logic fall_event_flag_q;
	logic [7:0] status_d;
	logic [7:0] sfr_rdata_q;
	logic sfr_sel_q;

	// ==========================================
	// Address decode
	always_comb begin
		if (sfr_req_i.addr == `CMPCSR_ADDR) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end
	assign wr_hit = hit & sfr_req_i.wr;

	// ==========================================
	// Result synchronisation and edge detection
	cmpcsr_edge u_edge (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.async_i(compare_result_i),
		.level_o(result_sync),
		.rise_o(rise_evt),
		.fall_o(fall_evt)
	);

	// ==========================================
	// Control fields
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			comparator_on_q <= 1'b0;
		end else if (wr_hit) begin
			comparator_on_q <= sfr_req_i.wdata[`CMPCSR_BIT_ON];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			upper_hysteresis_sel_q <= `CMPCSR_HYST_RESET;
			lower_hysteresis_sel_q <= `CMPCSR_HYST_RESET;
		end else if (wr_hit) begin
			upper_hysteresis_sel_q <= sfr_req_i.wdata[`CMPCSR_UPPER_HI:`CMPCSR_UPPER_LO];
			lower_hysteresis_sel_q <= sfr_req_i.wdata[`CMPCSR_LOWER_HI:`CMPCSR_LOWER_LO];
		end
	end

	// ==========================================
	// Sticky edge flags; a new edge wins over a clearing write so none is lost
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rise_event_flag_q <= 1'b0;
		end else if (rise_evt) begin
			rise_event_flag_q <= 1'b1;
		end else if (wr_hit) begin
			rise_event_flag_q <= sfr_req_i.wdata[`CMPCSR_BIT_RISE];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fall_event_flag_q <= 1'b0;
		end else if (fall_evt) begin
			fall_event_flag_q <= 1'b1;
		end else if (wr_hit) begin
			fall_event_flag_q <= sfr_req_i.wdata[`CMPCSR_BIT_FALL];
		end
	end

	// ==========================================
	// Read path, registered so the outputs come straight from flip-flops
	always_comb begin
		status_d = `CMPCSR_RESET_VAL;
		status_d[`CMPCSR_BIT_ON] = comparator_on_q;
		status_d[`CMPCSR_BIT_RESULT] = result_sync;
		status_d[`CMPCSR_BIT_RISE] = rise_event_flag_q;
		status_d[`CMPCSR_BIT_FALL] = fall_event_flag_q;
		status_d[`CMPCSR_UPPER_HI:`CMPCSR_UPPER_LO] = upper_hysteresis_sel_q;
		status_d[`CMPCSR_LOWER_HI:`CMPCSR_LOWER_LO] = lower_hysteresis_sel_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sfr_rdata_q <= `CMPCSR_RESET_VAL;
			sfr_sel_q <= 1'b0;
		end else begin
			sfr_sel_q <= hit & sfr_req_i.rd;
			if (hit & sfr_req_i.rd) begin
				sfr_rdata_q <= status_d;
			end else begin
				sfr_rdata_q <= `CMPCSR_RESET_VAL;
			end
		end
	end

	assign sfr_rdata_o = sfr_rdata_q;
	assign sfr_sel_o = sfr_sel_q;
	assign ctrl_o.comparator_on = comparator_on_q;
	assign ctrl_o.upper_hysteresis_sel = cmpcsr_pkg::cmpcsr_hyst_type'(upper_hysteresis_sel_q);
	assign ctrl_o.lower_hysteresis_sel = cmpcsr_pkg::cmpcsr_hyst_type'(lower_hysteresis_sel_q);

endmodule : cmpcsr_top

// file: bench/cmpcsr_core_model.sv
// Analog comparator core model
`timescale 1ns/100ps
module cmpcsr_core_model (
	input wire cmpcsr_pkg::cmpcsr_ctrl_type ctrl_i,
	input wire logic [15:0] plus_mv_i,
	input wire logic [15:0] minus_mv_i,
	output logic result_o
);
	// ====
	// No hysteresis: stimulus never sits near the threshold; off drives low
	assign result_o = ctrl_i.comparator_on && plus_mv_i > minus_mv_i;
endmodule : cmpcsr_core_model

// file: bench/cmpcsr_chk.sv
// Assertions on the comparator control register ports
`timescale 1ns/100ps
module cmpcsr_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire cmpcsr_pkg::cmpcsr_sfr_req_type sfr_req_i,
	input wire logic compare_result_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_sel_o,
	input wire cmpcsr_pkg::cmpcsr_ctrl_type ctrl_o
);
	// ====
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire wr_hit = sfr_req_i.wr && sfr_req_i.addr == 8'h9b;
	wire rd_hit = sfr_req_i.rd && sfr_req_i.addr == 8'h9b;
	logic rise_seen_q;
	// Remembers a rise flag read back, forgotten on any write to address 0x9b
	always_ff @(posedge clk_sys_i) begin
		rise_seen_q <= !rst_i && !wr_hit && (rise_seen_q || (sfr_sel_o && sfr_rdata_o[5] && !$past(wr_hit)));
	end
	sequence rise_s;
		(!compare_result_i && !wr_hit)[*3] ##1 (compare_result_i && !wr_hit)[*4] ##0 rd_hit;
	endsequence
	sequence fall_s;
		(compare_result_i && !wr_hit)[*3] ##1 (!compare_result_i && !wr_hit)[*4] ##0 rd_hit;
	endsequence
	on_write_a: assert property (wr_hit |=> ctrl_o.comparator_on == $past(sfr_req_i.wdata[7]))
		else $error("enable bit not taken");
	upper_write_a: assert property (wr_hit |=> ctrl_o.upper_hysteresis_sel == $past(sfr_req_i.wdata[3:2]))
		else $error("upper field not taken");
	lower_write_a: assert property (wr_hit |=> ctrl_o.lower_hysteresis_sel == $past(sfr_req_i.wdata[1:0]))
		else $error("lower field not taken");
	read_sel_a: assert property (rd_hit |=> sfr_sel_o)
		else $error("read not answered");
	unmapped_quiet_a: assert property (!rd_hit |=> !sfr_sel_o && sfr_rdata_o == 8'h00)
		else $error("stray read answer");
	result_bit_a: assert property ($stable(compare_result_i)[*3] ##0 rd_hit |=> sfr_rdata_o[6] == $past(compare_result_i))
		else $error("result bit wrong");
	rise_flag_a: assert property (rise_s |=> sfr_rdata_o[5])
		else $error("rise flag missing");
	fall_flag_a: assert property (fall_s |=> sfr_rdata_o[4])
		else $error("fall flag missing");
	flag_hold_a: assert property (rise_seen_q && rd_hit |=> sfr_rdata_o[5])
		else $error("flag dropped");
endmodule : cmpcsr_chk

bind cmpcsr_top cmpcsr_chk chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i),
	.compare_result_i(compare_result_i), .sfr_rdata_o(sfr_rdata_o), .sfr_sel_o(sfr_sel_o), .ctrl_o(ctrl_o));

// file: bench/comparator_control_register_tb_top.sv
// Testbench for the comparator control register
`timescale 1ns/100ps
module comparator_control_register_tb_top;
	// ====
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic res;
	logic sel;
	logic [7:0] rdata;
	logic [15:0] plus_mv = 16'h0000;
	cmpcsr_pkg::cmpcsr_sfr_req_type req = '0;
	cmpcsr_pkg::cmpcsr_ctrl_type ctrl;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	cmpcsr_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_req_i(req), .compare_result_i(res),
		.sfr_rdata_o(rdata), .sfr_sel_o(sel), .ctrl_o(ctrl));
	cmpcsr_core_model core (.ctrl_i(ctrl), .plus_mv_i(plus_mv), .minus_mv_i(16'h0064), .result_o(res));
	task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic access(logic [7:0] a, logic w, logic [7:0] d);
		@(negedge clk_sys_i);
		req = '{a, w, !w, d};
		@(negedge clk_sys_i);
		req = '0;
	endtask : access
	// Waits a bounded time for the strobe, so an unmapped read reads as all zero
	task automatic expect_rd(logic [7:0] a, logic [8:0] exp);
		access(a, 0, 8'h00);
		repeat (2) if (sel !== 1'b1) @(negedge clk_sys_i);
		check("read", {sel, rdata}, exp);
	endtask : expect_rd
	task automatic t_fields();
		for (int c = 0; c < 4; c++) begin
			access(8'h9b, 1, {4'hc, c[1:0], ~c[1:0]});
			@(negedge clk_sys_i);
			check("ctrl", {4'h0, ctrl}, {5'h01, c[1:0], ~c[1:0]});
			expect_rd(8'h9b, {5'h18, c[1:0], ~c[1:0]});
		end
		access(8'h9b, 1, 8'h00);
		@(negedge clk_sys_i);
		check("ctrl", {4'h0, ctrl}, 9'h000);
		$display("test fields done");
	endtask : t_fields
	task automatic t_edges();
		access(8'h9b, 1, 8'h80);
		access(8'h9b, 1, 8'h80);
		repeat (3) @(negedge clk_sys_i);
		plus_mv = 16'h00c8;
		repeat (2) @(negedge clk_sys_i);
		expect_rd(8'h9b, 9'h1e0);
		plus_mv = 16'h0000;
		repeat (2) @(negedge clk_sys_i);
		expect_rd(8'h9b, 9'h1b0);
		access(8'h9b, 1, 8'h80);
		expect_rd(8'h9b, 9'h180);
		$display("test edges done");
	endtask : t_edges
	// A reset in mid-run must drop the fields and the flags that writes have raised
	task automatic t_midreset();
		access(8'h9b, 1, 8'hb6);
		expect_rd(8'h9b, 9'h1b6);
		rst_i = 1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 0;
		check("ctrl", {4'h0, ctrl}, 9'h000);
		expect_rd(8'h9b, 9'h100);
		$display("test midreset done");
	endtask : t_midreset
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys_i);
		rst_i = 0;
		expect_rd(8'h9b, 9'h100);
		expect_rd(8'h9a, 9'h000);
		$display("test reset done");
		t_fields();
		t_edges();
		t_midreset();
		stop_test();
	end
endmodule : comparator_control_register_tb_top
